//--- core/mies_core.sv
// Our own choices: the placing of the registers and the Wishbone register port.
`timescale 1ns/1ps
module mies_core
  import mies_pkg::*;
#(
  parameter int DEPTH = STACK_DEPTH
) (
  input  wire logic          clk_i,
  input  wire logic          rst_i,
  // instruction stream: one word offered per cycle with valid
  input  wire logic [13:0]   insn_i,
  input  wire logic          insn_valid_i,
  output logic               insn_ready_o,
  // file register port (data returned in the same cycle)
  output logic      [6:0]    faddr_o,
  input  wire logic [7:0]    frdata_i,
  output logic               fwe_o,
  output logic      [7:0]    fwdata_o,
  // side effects toward the rest of the core
  output logic      [PC_W-1:0] pc_o,
  output logic               wdt_clear_o,
  output logic               sleep_o,
  output logic      [7:0]    option_o,
  output logic      [7:0]    dir_a_o,
  output logic      [7:0]    dir_b_o,
  output logic               irq_enable_o,
  // wishbone classic slave
  input  wire logic          wb_cyc_i,
  input  wire logic          wb_stb_i,
  input  wire logic          wb_we_i,
  input  wire logic [7:0]    wb_adr_i,
  input  wire logic [3:0]    wb_sel_i,
  input  wire logic [31:0]   wb_dat_i,
  output logic      [31:0]   wb_dat_o,
  output logic               wb_ack_o
);
  typedef enum logic [1:0] {MIES_RUN, MIES_FLUSH, MIES_SLEEP} mies_state_t;

  mies_state_t       state_r;
  logic [7:0]        acc_r;
  logic [7:0]        status_r;
  logic [PC_W-1:0]   pc_r;
  logic [7:0]        option_r;
  logic [7:0]        dir_a_r;
  logic [7:0]        dir_b_r;
  logic [7:0]        irqc_r;
  logic [1:0]        push_r;
  logic [PC_W-1:0]   push_addr_r;
  logic              wdt_clr_r;
  logic              ack_r;
  logic [31:0]       rdat_r;
  logic [7:0]        res;
  logic              wr_c, wr_dc, wr_z, c_new, dc_new;
  logic [PC_W-1:0]   head;
  logic              exec;
  logic              dest_file;
  logic              is_byte, is_store, is_opt, is_sleep, is_dir;
  logic              is_ret, is_iret, is_retl, is_skip, is_lit;
  logic              pops;
  logic              wb_hit;

  mies_alu u_alu (
    .insn_i  (insn_i),
    .acc_i   (acc_r),
    .fval_i  (frdata_i),
    .carry_i (status_r[ST_C]),
    .res_o   (res),
    .wr_c_o  (wr_c),
    .wr_dc_o (wr_dc),
    .wr_z_o  (wr_z),
    .c_o     (c_new),
    .dc_o    (dc_new)
  );

  mies_stack #(.DEPTH(DEPTH), .AW(PC_W)) u_stack (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .push_i      (push_r[0]),
    .push_addr_i (push_addr_r),
    .pop_i       (pops),
    .head_o      (head)
  );

  // decode of the word now at the execute stage
  assign exec      = insn_valid_i && state_r == MIES_RUN;
  // only the covered opcodes: other words of the set just step the counter
  assign is_lit    = insn_i[13:10] == OPG_LOAD_LIT || insn_i[13:10] == OPG_RET_LIT
                     || insn_i[13:9] == OPG_LIT_SUB || insn_i[13:8] == OP_OR_LIT
                     || insn_i[13:8] == OP_XOR_LIT;
  assign is_byte   = insn_i[13:8] inside {OP_SUB_FILE, OP_OR_FILE, OP_XOR_FILE, OP_COPY_FILE,
                     OP_INC_FILE, OP_ROT_R, OP_ROT_L, OP_NIB_EXCH, OP_INC_SKIP};
  assign is_store  = (insn_i & CW_STORE_MASK) == CW_STORE_VAL;
  assign is_opt    = insn_i == CW_OPTION;
  assign is_sleep  = insn_i == CW_SLEEP;
  assign is_dir    = (insn_i & CW_DIR_MASK) == CW_DIR_BASE && !is_opt && !is_sleep
                     && (insn_i[2:0] == DIR_PORT_A || insn_i[2:0] == DIR_PORT_B);
  assign is_ret    = insn_i == CW_RETURN;
  assign is_iret   = insn_i == CW_IRQ_RETURN;
  assign is_retl   = insn_i[13:10] == OPG_RET_LIT;
  assign is_skip   = insn_i[13:8] == OP_INC_SKIP;
  assign dest_file = insn_i[DEST_BIT];
  assign pops      = exec && (is_ret || is_iret || is_retl);

  // file port: address from low seven bits, write back when destination is file
  assign faddr_o  = insn_i[FADDR_W-1:0];
  assign fwe_o    = exec && ((is_byte && dest_file) || is_store);
  assign fwdata_o = is_store ? acc_r : res;
  assign insn_ready_o = state_r != MIES_SLEEP;

  // sequencing: a skip whose result is zero or a return costs one extra flushed cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r <= MIES_RUN;
    end else begin
      case (state_r)
        MIES_RUN: begin
          if (exec && is_skip && res == 8'h00) begin
            state_r <= MIES_FLUSH;
          end else if (pops) begin
            state_r <= MIES_FLUSH;
          end else if (exec && is_sleep) begin
            state_r <= MIES_SLEEP;
          end
        end
        MIES_FLUSH: state_r <= MIES_RUN;
        MIES_SLEEP: begin
          if (push_r[1]) state_r <= MIES_RUN; // software wake
        end
        default: state_r <= MIES_RUN;
      endcase
    end
  end

  // program counter: advance per word, reload from stack head on return
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pc_r <= '0;
    end else if (pops) begin
      pc_r <= head;
    end else if (exec || state_r == MIES_FLUSH) begin
      pc_r <= pc_r + 1'b1;
    end
  end

  // accumulator: byte results with destination 0 and literal results
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      acc_r <= RST_ACC;
    end else if (wb_hit && wb_we_i && wb_adr_i == REG_ACC && wb_sel_i[0]) begin
      acc_r <= wb_dat_i[7:0];
    end else if (exec && is_byte && !dest_file) begin
      acc_r <= res;
    end else if (exec && is_lit) begin
      acc_r <= res;
    end
  end

  // status flags: only those the operation names are touched
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      status_r <= RST_STATUS;
    end else if (wb_hit && wb_we_i && wb_adr_i == REG_STATUS && wb_sel_i[0]) begin
      status_r <= wb_dat_i[7:0];
    end else if (exec && is_sleep) begin
      status_r[ST_PD] <= 1'b0;
      status_r[ST_TO] <= 1'b1;
    end else if (exec && (is_byte || is_lit)) begin
      if (wr_c)  status_r[ST_C]  <= c_new;
      if (wr_dc) status_r[ST_DC] <= dc_new;
      if (wr_z)  status_r[ST_Z]  <= res == 8'h00;
    end
  end

  // legacy loads of option and direction registers; 1 means input
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      option_r <= RST_OPTION;
      dir_a_r  <= RST_DIR;
      dir_b_r  <= RST_DIR;
    end else if (exec && is_opt) begin
      option_r <= acc_r;
    end else if (exec && is_dir) begin
      if (insn_i[2:0] == DIR_PORT_A) dir_a_r <= acc_r;
      else dir_b_r <= acc_r;
    end else if (wb_hit && wb_we_i && wb_sel_i[0]) begin
      if (wb_adr_i == REG_OPTION) option_r <= wb_dat_i[7:0];
      if (wb_adr_i == REG_DIR_A) dir_a_r <= wb_dat_i[7:0];
      if (wb_adr_i == REG_DIR_B) dir_b_r <= wb_dat_i[7:0];
    end
  end

  // interrupt control: irq-return sets the global enable, software wins otherwise
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irqc_r <= 8'h00;
    end else if (exec && is_iret) begin
      irqc_r[GIE_BIT] <= 1'b1;
    end else if (wb_hit && wb_we_i && wb_adr_i == REG_IRQC && wb_sel_i[0]) begin
      irqc_r <= wb_dat_i[7:0];
    end
  end

  // watchdog clear pulse on sleep; the counter itself lives elsewhere
  always_ff @(posedge clk_i) begin
    if (rst_i) wdt_clr_r <= 1'b0;
    else wdt_clr_r <= exec && is_sleep;
  end

  // control writes: bit0 pushes data onto the stack, bit1 wakes from sleep
  // the address is latched so the master may drop its data once ack is seen
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      push_r      <= 2'h0;
      push_addr_r <= '0;
    end else if (wb_hit && wb_we_i && wb_adr_i == REG_CTRL && wb_sel_i[0]) begin
      push_r      <= wb_dat_i[1:0];
      push_addr_r <= wb_dat_i[PC_W-1:0];
    end else begin
      push_r <= 2'h0;
    end
  end

  // wishbone: one-cycle registered ack, unmapped reads give zero
  assign wb_hit = wb_cyc_i && wb_stb_i && !ack_r;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r  <= 1'b0;
      rdat_r <= 32'h0000_0000;
    end else begin
      ack_r <= wb_hit;
      case (wb_adr_i)
        REG_ACC:    rdat_r <= {24'h000000, acc_r};
        REG_STATUS: rdat_r <= {24'h000000, status_r[7:6], state_r == MIES_SLEEP,
                               status_r[4:0]};
        REG_PC:     rdat_r <= {{(32-PC_W){1'b0}}, pc_r};
        REG_OPTION: rdat_r <= {24'h000000, option_r};
        REG_DIR_A:  rdat_r <= {24'h000000, dir_a_r};
        REG_DIR_B:  rdat_r <= {24'h000000, dir_b_r};
        REG_IRQC:   rdat_r <= {24'h000000, irqc_r};
        default:    rdat_r <= 32'h0000_0000;
      endcase
    end
  end

  assign wb_ack_o     = ack_r;
  assign wb_dat_o     = rdat_r;
  assign pc_o         = pc_r;
  assign wdt_clear_o  = wdt_clr_r;
  assign sleep_o      = state_r == MIES_SLEEP;
  assign option_o     = option_r;
  assign dir_a_o      = dir_a_r;
  assign dir_b_o      = dir_b_r;
  assign irq_enable_o = irqc_r[GIE_BIT];
endmodule : mies_core

//--- pkg/mies_pkg.sv
package mies_pkg;
  // instruction word layout
  localparam int INSN_W      = 14;
  localparam int FADDR_W     = 7;
  localparam int DEST_BIT    = 7;
  localparam int LIT_W       = 8;
  localparam int PC_W        = 13;
  localparam int STACK_DEPTH = 8;
  // byte and literal opcodes, bits 13:8
  localparam logic [5:0] OP_SUB_FILE  = 6'h02;
  localparam logic [5:0] OP_OR_FILE   = 6'h04;
  localparam logic [5:0] OP_XOR_FILE  = 6'h06;
  localparam logic [5:0] OP_COPY_FILE = 6'h08;
  localparam logic [5:0] OP_INC_FILE  = 6'h0A;
  localparam logic [5:0] OP_ROT_R     = 6'h0C;
  localparam logic [5:0] OP_ROT_L     = 6'h0D;
  localparam logic [5:0] OP_NIB_EXCH  = 6'h0E;
  localparam logic [5:0] OP_INC_SKIP  = 6'h0F;
  localparam logic [5:0] OP_OR_LIT    = 6'h38;
  localparam logic [5:0] OP_XOR_LIT   = 6'h3A;
  // literal opcode groups, bits 13:10
  localparam logic [3:0] OPG_LOAD_LIT = 4'hC;
  localparam logic [3:0] OPG_RET_LIT  = 4'hD;
  // bits 13:9 for literal minus accumulator
  localparam logic [4:0] OPG_LIT_SUB  = 5'h1E;
  // full-word control encodings
  localparam logic [13:0] CW_RETURN     = 14'h0008;
  localparam logic [13:0] CW_IRQ_RETURN = 14'h0009;
  localparam logic [13:0] CW_OPTION     = 14'h0062;
  localparam logic [13:0] CW_SLEEP      = 14'h0063;
  localparam logic [13:0] CW_DIR_BASE   = 14'h0060;
  localparam logic [13:0] CW_DIR_MASK   = 14'h3FF8;
  localparam logic [13:0] CW_NOP_MASK   = 14'h3F9F;
  localparam logic [13:0] CW_STORE_MASK = 14'h3F80;
  localparam logic [13:0] CW_STORE_VAL  = 14'h0080;
  localparam logic [2:0]  DIR_PORT_A    = 3'h5;
  localparam logic [2:0]  DIR_PORT_B    = 3'h6;
  localparam int          GIE_BIT       = 7;
  // reset values
  localparam logic [7:0]  RST_OPTION    = 8'hFF;
  localparam logic [7:0]  RST_DIR       = 8'hFF;
  localparam logic [7:0]  RST_ACC       = 8'h00;
  localparam logic [7:0]  RST_STATUS    = 8'h18;
  // wishbone register map (byte addresses)
  localparam logic [7:0] REG_ACC    = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_PC     = 8'h08;
  localparam logic [7:0] REG_OPTION = 8'h0C;
  localparam logic [7:0] REG_DIR_A  = 8'h10;
  localparam logic [7:0] REG_DIR_B  = 8'h14;
  localparam logic [7:0] REG_IRQC   = 8'h18;
  localparam logic [7:0] REG_CTRL   = 8'h1C;
  // status bit positions inside the status register
  localparam int ST_C   = 0;
  localparam int ST_DC  = 1;
  localparam int ST_Z   = 2;
  localparam int ST_PD  = 3;
  localparam int ST_TO  = 4;
  localparam int ST_SLP = 5;
endpackage : mies_pkg

//--- core/mies_alu.sv
`timescale 1ns/1ps
// combinational datapath: result and flag effects of one byte or literal operation
module mies_alu
  import mies_pkg::*;
(
  input  wire logic [13:0] insn_i,
  input  wire logic [7:0]  acc_i,
  input  wire logic [7:0]  fval_i,
  input  wire logic        carry_i,
  output logic      [7:0]  res_o,
  output logic             wr_c_o,
  output logic             wr_dc_o,
  output logic             wr_z_o,
  output logic             c_o,
  output logic             dc_o
);
  logic [7:0] lit;
  logic [8:0] sum;
  logic [4:0] nsum;

  // a - b as a + ~b + 1: carry high means no borrow
  function automatic logic [8:0] sub9(input logic [7:0] a, input logic [7:0] b);
    sub9 = {1'b0, a} + {1'b0, ~b} + 9'h001;
  endfunction : sub9

  function automatic logic [4:0] subn(input logic [3:0] a, input logic [3:0] b);
    subn = {1'b0, a} + {1'b0, ~b} + 5'h01;
  endfunction : subn

  assign lit = insn_i[LIT_W-1:0];

  // one decode per instruction class; unknown words leave everything unchanged
  always_comb begin
    res_o   = fval_i;
    wr_c_o  = 1'b0;
    wr_dc_o = 1'b0;
    wr_z_o  = 1'b0;
    c_o     = carry_i;
    dc_o    = 1'b0;
    sum     = 9'h000;
    nsum    = 5'h00;
    if (insn_i[13:9] == OPG_LIT_SUB) begin
      sum = sub9(lit, acc_i);
      nsum = subn(lit[3:0], acc_i[3:0]);
      res_o = sum[7:0];
      c_o = sum[8];
      dc_o = nsum[4];
      {wr_c_o, wr_dc_o, wr_z_o} = 3'h7;
    end else if (insn_i[13:10] == OPG_LOAD_LIT || insn_i[13:10] == OPG_RET_LIT) begin
      res_o = lit;
    end else begin
      case (insn_i[13:8])
        OP_OR_LIT: begin
          res_o = acc_i | lit;
          wr_z_o = 1'b1;
        end
        OP_XOR_LIT: begin
          res_o = acc_i ^ lit;
          wr_z_o = 1'b1;
        end
        OP_OR_FILE: begin
          res_o = acc_i | fval_i;
          wr_z_o = 1'b1;
        end
        OP_XOR_FILE: begin
          res_o = acc_i ^ fval_i;
          wr_z_o = 1'b1;
        end
        OP_COPY_FILE: begin
          res_o = fval_i;
          wr_z_o = 1'b1;
        end
        OP_INC_FILE: begin
          sum = {1'b0, fval_i} + 9'h001;
          nsum = {1'b0, fval_i[3:0]} + 5'h01;
          res_o = sum[7:0];
          c_o = sum[8];
          dc_o = nsum[4];
          {wr_c_o, wr_dc_o, wr_z_o} = 3'h7;
        end
        OP_INC_SKIP: begin
          res_o = fval_i + 8'h01;
        end
        OP_SUB_FILE: begin
          sum = sub9(fval_i, acc_i);
          nsum = subn(fval_i[3:0], acc_i[3:0]);
          res_o = sum[7:0];
          c_o = sum[8];
          dc_o = nsum[4];
          {wr_c_o, wr_dc_o, wr_z_o} = 3'h7;
        end
        OP_ROT_L: begin
          res_o = {fval_i[6:0], carry_i};
          c_o = fval_i[7];
          wr_c_o = 1'b1;
        end
        OP_ROT_R: begin
          res_o = {carry_i, fval_i[7:1]};
          c_o = fval_i[0];
          wr_c_o = 1'b1;
        end
        OP_NIB_EXCH: begin
          res_o = {fval_i[3:0], fval_i[7:4]};
        end
        default: begin
          res_o = fval_i;
        end
      endcase
    end
  end
endmodule : mies_alu

//--- core/mies_stack.sv
`timescale 1ns/1ps
// circular return stack; overflow silently wraps like the original core
module mies_stack
  import mies_pkg::*;
#(
  parameter int DEPTH = STACK_DEPTH,
  parameter int AW    = PC_W
) (
  input  wire logic          clk_i,
  input  wire logic          rst_i,
  input  wire logic          push_i,
  input  wire logic [AW-1:0] push_addr_i,
  input  wire logic          pop_i,
  output logic      [AW-1:0] head_o
);
  logic [AW-1:0]            mem_r [DEPTH];
  logic [$clog2(DEPTH)-1:0] ptr_r;

  // pointer names the next free slot; head is the slot below it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ptr_r <= '0;
    end else if (push_i && pop_i) begin
      mem_r[ptr_r - 1'b1] <= push_addr_i; // pop and push together replace the head
    end else if (push_i) begin
      mem_r[ptr_r] <= push_addr_i;
      ptr_r <= ptr_r + 1'b1;
    end else if (pop_i) begin
      ptr_r <= ptr_r - 1'b1;
    end
  end

  assign head_o = mem_r[ptr_r - 1'b1];
endmodule : mies_stack

//--- bench/mies_core_sva.sv
`timescale 1ns/1ps
// port-level checks for the execute block; helper logic tracks which word is discarded
module mies_core_sva
  import mies_pkg::*;
(
  input wire logic            clk_i,
  input wire logic            rst_i,
  input wire logic [13:0]     insn_i,
  input wire logic            insn_valid_i,
  input wire logic            insn_ready_o,
  input wire logic [6:0]      faddr_o,
  input wire logic [7:0]      frdata_i,
  input wire logic            fwe_o,
  input wire logic [7:0]      fwdata_o,
  input wire logic [PC_W-1:0] pc_o,
  input wire logic            wdt_clear_o,
  input wire logic            sleep_o,
  input wire logic            irq_enable_o,
  input wire logic            wb_cyc_i,
  input wire logic            wb_stb_i,
  input wire logic            wb_ack_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic       flush_r;
  logic       take;
  logic       run;
  logic       byte_op;
  logic [5:0] op;
  // decode shared by the properties below
  assign take    = insn_valid_i && insn_ready_o;
  assign run     = take && !flush_r;
  assign op      = insn_i[13:8];
  assign byte_op = op inside {OP_SUB_FILE, OP_OR_FILE, OP_XOR_FILE, OP_COPY_FILE,
                              OP_INC_FILE, OP_ROT_R, OP_ROT_L, OP_NIB_EXCH, OP_INC_SKIP};
  // a return or a zero skip makes the next cycle a discarded one, word or not
  always_ff @(posedge clk_i) begin
    if (rst_i) flush_r <= 1'b0;
    else flush_r <= run && (insn_i == CW_RETURN || insn_i == CW_IRQ_RETURN
      || insn_i[13:10] == OPG_RET_LIT || (op == OP_INC_SKIP && frdata_i == 8'hFF));
  end
  // sleep entry: one clear pulse, then the core stays parked
  sequence s_sleep;
    wdt_clear_o && sleep_o ##1 !wdt_clear_o && !insn_ready_o;
  endsequence
  sequence s_ack;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  a_faddr_low_bits: assert property (faddr_o == insn_i[6:0])
    else $error("file address differs from word low bits");
  a_dest_acc_only: assert property (
    run && byte_op && !insn_i[DEST_BIT] |-> !fwe_o)
    else $error("file written although accumulator selected");
  a_inc_value: assert property (
    run && op == OP_INC_FILE && insn_i[DEST_BIT] |-> fwe_o && fwdata_o == frdata_i + 8'h01)
    else $error("increment result wrong");
  a_skip_discard: assert property (
    run && op == OP_INC_SKIP && frdata_i == 8'hFF |-> (!fwe_o || fwdata_o == 8'h00) ##1 !fwe_o)
    else $error("word after zero skip not discarded");
  a_nibble_swap: assert property (
    run && op == OP_NIB_EXCH && fwe_o |-> fwdata_o == {frdata_i[3:0], frdata_i[7:4]})
    else $error("nibble exchange result wrong");
  a_nop_pc_step: assert property (
    run && (insn_i & CW_NOP_MASK) == 14'h0000 |-> !fwe_o ##1 pc_o == $past(pc_o) + 1'b1)
    else $error("no-op changed more than the counter");
  a_return_flush: assert property (
    run && insn_i == CW_RETURN |=> !fwe_o ##1 pc_o == $past(pc_o) + 1'b1)
    else $error("return did not take two cycles");
  a_irq_enable: assert property (run && insn_i == CW_IRQ_RETURN |=> irq_enable_o)
    else $error("global enable not set by irq return");
  a_sleep_enter: assert property (run && insn_i == CW_SLEEP |=> s_sleep)
    else $error("sleep entry sequence wrong");
  a_ack_pulse: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> s_ack)
    else $error("bus acknowledge not a single pulse");
endmodule : mies_core_sva

bind mies_core mies_core_sva u_sva (.clk_i, .rst_i, .insn_i, .insn_valid_i, .insn_ready_o,
  .faddr_o, .frdata_i, .fwe_o, .fwdata_o, .pc_o, .wdt_clear_o, .sleep_o, .irq_enable_o,
  .wb_cyc_i, .wb_stb_i, .wb_ack_o);

//--- bench/mies_core_tb.sv
`timescale 1ns/1ps
module mies_core_tb
  import mies_pkg::*;
;
  logic            clk_i, rst_i, insn_valid_i, insn_ready_o, fwe_o, wdt_clear_o, sleep_o;
  logic            irq_enable_o, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [13:0]     insn_i;
  logic [6:0]      faddr_o;
  logic [7:0]      frdata_i, fwdata_o, option_o, dir_a_o, dir_b_o, wb_adr_i;
  logic [3:0]      wb_sel_i;
  logic [31:0]     wb_dat_i, wb_dat_o, q;
  logic [PC_W-1:0] pc_o, pc;
  logic [7:0]      mem [128];
  logic [7:0]      acc, st, opt, da, db;
  logic [12:0]     stk [$];
  bit              ie, slp, fl;
  int              mismatches, n_checks;
  mies_core dut (.clk_i, .rst_i, .insn_i, .insn_valid_i, .insn_ready_o, .faddr_o, .frdata_i,
    .fwe_o, .fwdata_o, .pc_o, .wdt_clear_o, .sleep_o, .option_o, .dir_a_o, .dir_b_o,
    .irq_enable_o, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
    .wb_dat_o, .wb_ack_o);
  // file memory answers in the same cycle, as the core expects
  assign frdata_i = mem[faddr_o];
  always @(posedge clk_i) if (fwe_o === 1'b1) mem[faddr_o] <= fwdata_o;
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : report_and_stop
  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk_val
  task automatic chk_flag(input logic got, input logic exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR t=%0t flag got %h exp %h", $time, got, exp);
    end
  endtask : chk_flag
  // classic single cycle; request held up to the edge that samples ack, data taken there
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_sel_i <= 4'hF;
    wb_dat_i <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    if (n >= 50) begin
      mismatches++;
      report_and_stop;
    end
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : wb
  // reference model of one word, then compare the file port in that cycle
  task automatic step(input logic [13:0] w);
    logic [7:0] f, r, k;
    logic [5:0] op;
    bit         wr, zf, by;
    f = mem[w[6:0]];
    k = w[7:0];
    op = w[13:8];
    r = 8'h00;
    wr = 0;
    zf = 0;
    by = 1;
    pc = pc + 1'b1;
    if (fl) fl = 0;
    else if (w == CW_RETURN || w == CW_IRQ_RETURN || w[13:10] == OPG_RET_LIT) begin
      pc = stk.pop_back();
      fl = 1;
      if (w[13:10] == OPG_RET_LIT) acc = k;
      if (w == CW_IRQ_RETURN) ie = 1;
    end else if (w == CW_OPTION) opt = acc;
    else if (w == CW_SLEEP) begin
      st[ST_PD] = 0;
      st[ST_TO] = 1;
      slp = 1;
    end else if ((w & CW_DIR_MASK) == CW_DIR_BASE) begin
      if (w[2:0] == DIR_PORT_A) da = acc;
      if (w[2:0] == DIR_PORT_B) db = acc;
    end else if ((w & CW_STORE_MASK) == CW_STORE_VAL) begin
      wr = 1;
      r = acc;
    end else if (w[13:12] == 2'b11) begin
      zf = 1;
      if (op == OP_OR_LIT) acc = acc | k;
      else if (op == OP_XOR_LIT) acc = acc ^ k;
      else if (w[13:9] == OPG_LIT_SUB) begin
        st[ST_C] = k >= acc;
        st[ST_DC] = k[3:0] >= acc[3:0];
        acc = k - acc;
      end else begin
        zf = 0;
        if (w[13:10] == OPG_LOAD_LIT) acc = k;
      end
      if (zf) st[ST_Z] = acc == 8'h00;
    end else if (op[5:4] == 2'b00) begin
      zf = 1;
      case (op)
        OP_OR_FILE:   r = acc | f;
        OP_XOR_FILE:  r = acc ^ f;
        OP_COPY_FILE: r = f;
        OP_SUB_FILE: begin
          r = f - acc;
          st[ST_C] = f >= acc;
          st[ST_DC] = f[3:0] >= acc[3:0];
        end
        OP_INC_FILE: begin
          r = f + 8'h01;
          st[ST_C] = f == 8'hFF;
          st[ST_DC] = f[3:0] == 4'hF;
        end
        OP_ROT_R: begin
          r = {st[ST_C], f[7:1]};
          st[ST_C] = f[0];
          zf = 0;
        end
        OP_ROT_L: begin
          r = {f[6:0], st[ST_C]};
          st[ST_C] = f[7];
          zf = 0;
        end
        OP_NIB_EXCH: begin
          r = {f[3:0], f[7:4]};
          zf = 0;
        end
        OP_INC_SKIP: begin
          r = f + 8'h01;
          fl = r == 8'h00;
          zf = 0;
        end
        default: by = 0;
      endcase
      if (by && zf) st[ST_Z] = r == 8'h00;
      if (by && w[DEST_BIT]) wr = 1;
      else if (by) acc = r;
    end
    chk_flag(fwe_o, wr);
    if (wr) chk_val(fwdata_o, r);
  endtask : step
  task automatic run(input logic [13:0] a, input logic [13:0] b, input bit two);
    for (int i = 0; i < (two ? 2 : 1); i++) begin
      @(posedge clk_i);
      insn_i <= i ? b : a;
      insn_valid_i <= 1'b1;
      @(negedge clk_i);
      step(i ? b : a);
    end
    @(posedge clk_i);
    insn_valid_i <= 1'b0;
  endtask : run
  // readback of everything the model tracks
  task automatic check_state;
    wb(1'b0, REG_ACC, 32'h0);
    chk_val(q[7:0], acc);
    wb(1'b0, REG_STATUS, 32'h0);
    chk_val(q[7:0], {2'b00, slp, st[4:0]});
    wb(1'b0, REG_PC, 32'h0);
    chk_val(q[12:0], pc);
    chk_val(option_o, opt);
    chk_val(dir_a_o, da);
    chk_val(dir_b_o, db);
    chk_flag(irq_enable_o, ie);
  endtask : check_state
  function automatic logic [13:0] pick();
    logic [5:0] ops [15];
    int         i;
    ops = '{6'h02, 6'h04, 6'h06, 6'h08, 6'h0A, 6'h0C, 6'h0D, 6'h0E, 6'h0F,
            6'h38, 6'h3A, 6'h30, 6'h33, 6'h3C, 6'h3D};
    i = $urandom_range(0, 18);
    if (i < 15) return {ops[i], 8'($urandom)};
    if (i == 15) return {7'h01, 7'($urandom)};
    if (i == 16) return {7'h00, 2'($urandom), 5'h00};
    if (i == 17) return CW_OPTION;
    return CW_DIR_BASE | 14'(5 + $urandom_range(0, 2));
  endfunction : pick
  initial begin
    logic [13:0] w;
    logic [12:0] ra [3];
    logic [13:0] rw [3];
    {rst_i, insn_valid_i, wb_cyc_i, wb_stb_i, wb_we_i} = 5'h10;
    {insn_i, wb_adr_i, wb_sel_i, wb_dat_i} = '0;
    {mismatches, n_checks, ie, slp, fl} = '0;
    {acc, st, pc, opt, da, db} = {RST_ACC, RST_STATUS, 13'h0000, RST_OPTION, RST_DIR, RST_DIR};
    void'($urandom(15));
    foreach (mem[i]) mem[i] = 8'($urandom);
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    // reset values, then an unmapped write and read
    check_state;
    wb(1'b1, 8'h20, 32'hFF);
    wb(1'b0, 8'h20, 32'h0);
    chk_val(q, 32'h0);
    $display("test reset done");
    // random words, each followed back to back by a store that a skip must discard
    repeat (200) begin
      acc = 8'($urandom);
      wb(1'b1, REG_ACC, {24'h0, acc});
      st = RST_STATUS | 8'($urandom_range(0, 7));
      wb(1'b1, REG_STATUS, {24'h0, st});
      w = pick();
      case ($urandom_range(0, 3))
        0: mem[w[6:0]] = 8'hFF;
        1: mem[w[6:0]] = acc;
        default: ;
      endcase
      run(w, 14'h00A1, 1'b1);
      check_state;
    end
    $display("test random done");
    // returns, each chained straight into a word the flush must swallow
    ra = '{13'h0A55, 13'h1231, 13'h0101};
    rw = '{CW_RETURN, 14'h3477, CW_IRQ_RETURN};
    for (int i = 0; i < 3; i++) begin
      wb(1'b1, REG_CTRL, 32'(ra[i]));
      stk.push_back(ra[i]);
    end
    for (int i = 0; i < 3; i++) begin
      run(rw[i], i < 2 ? rw[i + 1] : 14'h00A2, 1'b1);
      check_state;
    end
    $display("test return done");
    // sleep last: it clears the powerdown bit, which only reset or a status write sets again
    run(CW_SLEEP, 14'h0000, 1'b0);
    check_state;
    @(negedge clk_i);
    chk_flag(insn_ready_o, 1'b0);
    chk_flag(sleep_o, 1'b1);
    wb(1'b1, REG_CTRL, 32'h2);
    slp = 0;
    check_state;
    @(negedge clk_i);
    chk_flag(insn_ready_o, 1'b1);
    $display("test sleep done");
    report_and_stop;
  end
endmodule : mies_core_tb
